/* File: tmc_capture_filter.v */
`timescale 1ns/1ps
`include "tmc_regs.vh"
module tmc_capture_filter #(
	parameter SAMPLES = `TMC_FILTER_SAMPLES
) (
	clock,
	rst,
	sample_in,
	filter_enable,
	level_out
);
	input wire clock;
	input wire rst;
	input wire sample_in;
	input wire filter_enable;
	output reg level_out;

	// the live sample is the newest of the run, so history needs one bit less
	reg [SAMPLES-2:0] hist_reg;

	always @(posedge clock or posedge rst) begin
		if (rst) begin
			hist_reg <= {(SAMPLES-1){1'b0}};
			level_out <= 1'b0;
		end else begin
			hist_reg <= {hist_reg[SAMPLES-3:0], sample_in};
			if (!filter_enable) begin
				level_out <= sample_in;
			end else if (&{hist_reg, sample_in}) begin
				level_out <= 1'b1; // R12
			end else if (~|{hist_reg, sample_in}) begin
				level_out <= 1'b0; // R12
			end
		end
	end
endmodule

/* File: tmc_mode_control.v */
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
`include "tmc_regs.vh"
// Overview of operation
// R1 - nonzero channel action field hands the pin to the compare output
// R2 - compare output reaches pad only when direction bit selects output
// R3 - non-PWM match: 0 disconnected, 1 toggle, 2 low, 3 high
// R4 - register A holds action fields A 7:6, B 5:4, C 3:2
// R5 - waveform mode is register B bits 4:3 over register A bits 1:0
// R6 - mode 0 normal; modes 1..3 phase-correct PWM 8, 9, 10 bits
// R7 - modes 4 and C are clear-on-match, TOP from compare A
// R8 - modes 5..7 fast PWM at 8, 9, 10 bits
// R9 - mode 8 phase-frequency PWM TOP capture; mode 9 TOP compare A
// R10 - mode A phase-correct TOP capture; mode B TOP compare A
// R11 - mode E fast TOP capture; F fast TOP compare A; D reserved
// R12 - filter enable needs four equal samples before capture input changes
// R13 - edge select zero falling, one rising edge triggers capture
// R14 - capture edge copies counter to capture value and sets the flag
// R15 - capture-as-TOP modes disconnect the pin and disable capture
// R16 - register B bit 5 reads zero and ignores writes
// R17 - clock select 0 stop, 1 undivided, 2..5 divide 8/64/256/1024
// R18 - clock select 6 falling, 7 rising external pin edges, even as output
// R19 - PWM modes: action 2 non-inverted, 3 inverted waveform
// R20 - external pin synchronised, one-cycle count enable per qualifying edge
// R21 - writable control bits reset to zero: counter stopped, outputs off
module tmc_mode_control (
	clock,
	rst,
	addr,
	wdata,
	wr_stb,
	rd_stb,
	rdata,
	match_a,
	match_b,
	match_c,
	pwm_up,
	dir_a,
	dir_b,
	dir_c,
	counter_value,
	capture_pin,
	external_count_pin,
	count_enable,
	waveform_mode,
	wave_type,
	top_source,
	fixed_resolution,
	compare_out_a,
	compare_out_b,
	compare_out_c,
	pad_oe_a,
	pad_oe_b,
	pad_oe_c,
	override_a,
	override_b,
	override_c,
	capture_value,
	capture_flag
);
	input wire clock;
	input wire rst;
	input wire [`TMC_ADDR_W-1:0] addr;
	input wire [7:0] wdata;
	input wire wr_stb;
	input wire rd_stb;
	output reg [7:0] rdata;
	input wire match_a;
	input wire match_b;
	input wire match_c;
	input wire pwm_up;
	input wire dir_a;
	input wire dir_b;
	input wire dir_c;
	input wire [15:0] counter_value;
	input wire capture_pin;
	input wire external_count_pin;
	output reg count_enable;
	output reg [3:0] waveform_mode;
	output reg [2:0] wave_type;
	output reg [1:0] top_source;
	output reg [1:0] fixed_resolution;
	output reg compare_out_a;
	output reg compare_out_b;
	output reg compare_out_c;
	output reg pad_oe_a;
	output reg pad_oe_b;
	output reg pad_oe_c;
	output reg override_a;
	output reg override_b;
	output reg override_c;
	output reg [15:0] capture_value;
	output reg capture_flag;

	localparam CHANS = 3;
	localparam [1:0] SEL_NONE = 2'h0;
	localparam [1:0] SEL_WAVE = 2'h1;
	localparam [1:0] SEL_CAP_CLK = 2'h2;

	reg [7:0] wave_output_control_reg;
	reg [7:0] capture_clock_control_reg;
	reg ext_sync1_reg;
	reg ext_sync2_reg;
	reg ext_prev_reg;
	reg cap_sync1_reg;
	reg cap_sync2_reg;
	reg cap_prev_reg;
	reg [2:0] oc_reg;
	wire cap_filtered;
	wire tick_div8;
	wire tick_div64;
	wire tick_div256;
	wire tick_div1024;
	wire [1:0] chan_a_output_action;
	wire [1:0] chan_b_output_action;
	wire [1:0] chan_c_output_action;
	wire [1:0] waveform_mode_low;
	wire [1:0] waveform_mode_high;
	wire [3:0] waveform_mode_next;
	wire capture_filter_enable;
	wire capture_edge_select;
	wire [2:0] clock_source_select;
	wire pwm_mode;
	wire capture_is_top;
	wire [2:0] match_vec;
	wire [5:0] action_vec;
	wire [2:0] dir_vec;
	wire [2:0] oc_next;
	reg count_next;
	reg [2:0] type_next;
	reg [1:0] top_next;
	reg [1:0] res_next;
	reg capture_event;
	wire [1:0] addr_sel;
	genvar g;

	// one helper decodes type for both the output and the PWM test
	function [2:0] mode_type;
		input [3:0] m;
		begin
			if (m == `TMC_WM_NORMAL) begin
				mode_type = `TMC_TYPE_NORMAL; // R6
			end else if (m == `TMC_WM_CTC_A || m == `TMC_WM_CTC_A2) begin
				mode_type = `TMC_TYPE_CTC; // R7
			end else if (m == `TMC_WM_PC8 || m == `TMC_WM_PC9 || m == `TMC_WM_PC10) begin
				mode_type = `TMC_TYPE_PC; // R6
			end else if (m == `TMC_WM_PC_CAP || m == `TMC_WM_PC_A) begin
				mode_type = `TMC_TYPE_PC; // R10
			end else if (m == `TMC_WM_PFC_CAP || m == `TMC_WM_PFC_A) begin
				mode_type = `TMC_TYPE_PFC; // R9
			end else if (m == `TMC_WM_RSVD) begin
				mode_type = `TMC_TYPE_RSVD; // R11
			end else begin
				mode_type = `TMC_TYPE_FAST; // R8 R11
			end
		end
	endfunction

	// shared by the write and read paths so both see one register map
	function [1:0] reg_sel;
		input [`TMC_ADDR_W-1:0] a;
		begin
			if (a == `TMC_OFS_WAVE_CTRL) begin
				reg_sel = SEL_WAVE;
			end else if (a == `TMC_OFS_CAP_CLK_CTRL) begin
				reg_sel = SEL_CAP_CLK;
			end else begin
				reg_sel = SEL_NONE;
			end
		end
	endfunction

	function chan_action;
		input [1:0] act;
		input [0:0] pwm;
		input [0:0] match;
		input [0:0] up;
		input [0:0] cur;
		begin
			chan_action = cur;
			if (match && act != `TMC_ACT_OFF) begin
				if (!pwm) begin
					if (act == `TMC_ACT_TOGGLE) begin
						chan_action = ~cur; // R3
					end else begin
						chan_action = act == `TMC_ACT_SET; // R3
					end
				end else if (act == `TMC_ACT_CLEAR) begin
					chan_action = ~up; // R19
				end else if (act == `TMC_ACT_SET) begin
					chan_action = up; // R19
				end else begin
					// pwm action 1 only toggles on each match, a simplification
					chan_action = ~cur;
				end
			end
		end
	endfunction

	assign chan_a_output_action = wave_output_control_reg[`TMC_A_HI:`TMC_A_LO]; // R4
	assign chan_b_output_action = wave_output_control_reg[`TMC_B_HI:`TMC_B_LO]; // R4
	assign chan_c_output_action = wave_output_control_reg[`TMC_C_HI:`TMC_C_LO]; // R4
	assign waveform_mode_low = wave_output_control_reg[`TMC_WML_HI:`TMC_WML_LO];
	assign waveform_mode_high = capture_clock_control_reg[`TMC_WMH_HI:`TMC_WMH_LO];
	assign waveform_mode_next = {waveform_mode_high, waveform_mode_low}; // R5
	assign capture_filter_enable = capture_clock_control_reg[`TMC_FILT_BIT];
	assign capture_edge_select = capture_clock_control_reg[`TMC_EDGE_BIT];
	assign clock_source_select = capture_clock_control_reg[`TMC_CS_HI:`TMC_CS_LO];
	assign pwm_mode = mode_type(waveform_mode_next) == `TMC_TYPE_PC ||
		mode_type(waveform_mode_next) == `TMC_TYPE_PFC ||
		mode_type(waveform_mode_next) == `TMC_TYPE_FAST;
	assign capture_is_top = waveform_mode_next == `TMC_WM_PFC_CAP ||
		waveform_mode_next == `TMC_WM_PC_CAP || waveform_mode_next == `TMC_WM_FAST_CAP;
	assign match_vec = {match_c, match_b, match_a};
	assign action_vec = {chan_c_output_action, chan_b_output_action, chan_a_output_action};
	assign dir_vec = {dir_c, dir_b, dir_a};
	assign addr_sel = reg_sel(addr);

	// one slice per channel; each reads only its own field and match
	generate
		for (g = 0; g < CHANS; g = g + 1) begin : g_chan
			assign oc_next[g] = chan_action(action_vec[2*g+1 -: 2], pwm_mode, match_vec[g], pwm_up, oc_reg[g]); // R4
		end
	endgenerate

	tmc_prescaler u_prescaler (
		.clock(clock),
		.rst(rst),
		.tick_div8(tick_div8),
		.tick_div64(tick_div64),
		.tick_div256(tick_div256),
		.tick_div1024(tick_div1024)
	);

	tmc_capture_filter #(
		.SAMPLES(`TMC_FILTER_SAMPLES)
	) u_capture_filter (
		.clock(clock),
		.rst(rst),
		.sample_in(cap_sync2_reg),
		.filter_enable(capture_filter_enable),
		.level_out(cap_filtered)
	);

	always @* begin
		type_next = mode_type(waveform_mode_next);
		top_next = `TMC_TOP_FIXED;
		res_next = `TMC_RES_NONE;
		case (waveform_mode_next)
			`TMC_WM_NORMAL: top_next = `TMC_TOP_FIXED;
			`TMC_WM_PC8, `TMC_WM_FAST8: res_next = `TMC_RES_8; // R6 R8
			`TMC_WM_PC9, `TMC_WM_FAST9: res_next = `TMC_RES_9; // R6 R8
			`TMC_WM_PC10, `TMC_WM_FAST10: res_next = `TMC_RES_10; // R6 R8
			`TMC_WM_PFC_CAP, `TMC_WM_PC_CAP, `TMC_WM_FAST_CAP: top_next = `TMC_TOP_CAPTURE; // R9 R10 R11
			`TMC_WM_RSVD: top_next = `TMC_TOP_NONE; // R11
			default: top_next = `TMC_TOP_COMPARE_A; // R7 R9 R10 R11
		endcase
	end

	// ext pin is sampled whatever its direction, so software can clock it
	always @* begin
		count_next = 1'b0;
		case (clock_source_select)
			`TMC_CS_STOP: count_next = 1'b0; // R17
			`TMC_CS_DIV1: count_next = 1'b1; // R17
			`TMC_CS_DIV8: count_next = tick_div8; // R17
			`TMC_CS_DIV64: count_next = tick_div64; // R17
			`TMC_CS_DIV256: count_next = tick_div256; // R17
			`TMC_CS_DIV1024: count_next = tick_div1024; // R17
			`TMC_CS_EXT_FALL: count_next = ext_prev_reg & ~ext_sync2_reg; // R18 R20
			default: count_next = ~ext_prev_reg & ext_sync2_reg; // R18 R20
		endcase
	end

	always @* begin
		capture_event = 1'b0;
		if (!capture_is_top && cap_prev_reg != cap_filtered) begin // R15
			capture_event = (cap_filtered == capture_edge_select); // R13
		end
	end

	always @(posedge clock or posedge rst) begin
		if (rst) begin
			wave_output_control_reg <= `TMC_RESET_BYTE; // R21
			capture_clock_control_reg <= `TMC_RESET_BYTE; // R21
			rdata <= `TMC_RESET_BYTE;
			ext_sync1_reg <= 1'b0;
			ext_sync2_reg <= 1'b0;
			ext_prev_reg <= 1'b0;
			cap_sync1_reg <= 1'b0;
			cap_sync2_reg <= 1'b0;
			cap_prev_reg <= 1'b0;
			oc_reg <= 3'h0;
			count_enable <= 1'b0;
			waveform_mode <= `TMC_WM_NORMAL;
			wave_type <= `TMC_TYPE_NORMAL;
			top_source <= `TMC_TOP_FIXED;
			fixed_resolution <= `TMC_RES_NONE;
			compare_out_a <= 1'b0;
			compare_out_b <= 1'b0;
			compare_out_c <= 1'b0;
			pad_oe_a <= 1'b0;
			pad_oe_b <= 1'b0;
			pad_oe_c <= 1'b0;
			override_a <= 1'b0;
			override_b <= 1'b0;
			override_c <= 1'b0;
			capture_value <= 16'h0000;
			capture_flag <= 1'b0;
		end else begin
			if (wr_stb && addr_sel == SEL_WAVE) begin
				wave_output_control_reg <= wdata;
			end else if (wr_stb && addr_sel == SEL_CAP_CLK) begin
				capture_clock_control_reg <= wdata & `TMC_CAP_CLK_WMASK; // R16
			end
			if (rd_stb && addr_sel == SEL_WAVE) begin
				rdata <= wave_output_control_reg;
			end else if (rd_stb && addr_sel == SEL_CAP_CLK) begin
				rdata <= capture_clock_control_reg & `TMC_CAP_CLK_WMASK; // R16
			end else begin
				rdata <= `TMC_RESET_BYTE;
			end
			ext_sync1_reg <= external_count_pin;
			ext_sync2_reg <= ext_sync1_reg;
			ext_prev_reg <= ext_sync2_reg;
			cap_sync1_reg <= capture_pin;
			cap_sync2_reg <= cap_sync1_reg;
			cap_prev_reg <= cap_filtered;
			oc_reg <= oc_next;
			count_enable <= count_next;
			waveform_mode <= waveform_mode_next;
			wave_type <= type_next;
			top_source <= top_next;
			fixed_resolution <= res_next;
			override_a <= chan_a_output_action != `TMC_ACT_OFF; // R1
			override_b <= chan_b_output_action != `TMC_ACT_OFF; // R1
			override_c <= chan_c_output_action != `TMC_ACT_OFF; // R1
			pad_oe_a <= (chan_a_output_action != `TMC_ACT_OFF) & dir_vec[0]; // R2
			pad_oe_b <= (chan_b_output_action != `TMC_ACT_OFF) & dir_vec[1]; // R2
			pad_oe_c <= (chan_c_output_action != `TMC_ACT_OFF) & dir_vec[2]; // R2
			// value forced low while the direction bit is clear, keeps the pad quiet
			compare_out_a <= oc_next[0] & dir_vec[0]; // R2
			compare_out_b <= oc_next[1] & dir_vec[1]; // R2
			compare_out_c <= oc_next[2] & dir_vec[2]; // R2
			if (capture_event) begin
				capture_value <= counter_value; // R14
				capture_flag <= 1'b1; // R14
			end else begin
				capture_flag <= 1'b0;
			end
		end
	end
endmodule

/* File: tmc_mode_control_asserts.sv */
`timescale 1ns/1ps
module tmc_mode_control_asserts (
	clock,
	rst,
	addr,
	wdata,
	wr_stb,
	rd_stb,
	rdata,
	match_a,
	dir_a,
	count_enable,
	waveform_mode,
	top_source,
	compare_out_a,
	pad_oe_a,
	override_a,
	override_b,
	override_c,
	capture_flag
);
	input wire clock, rst, wr_stb, rd_stb, match_a, dir_a, count_enable;
	input wire compare_out_a, pad_oe_a, override_a, override_b, override_c, capture_flag;
	input wire [7:0] addr, wdata, rdata;
	input wire [3:0] waveform_mode;
	input wire [1:0] top_source;
	logic [7:0] wa_reg, wb_reg;
	// shadows load on the same edge as the control registers
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			wa_reg <= 8'h00;
			wb_reg <= 8'h00;
		end else if (wr_stb) begin
			if (addr == 8'h80)
				wa_reg <= wdata;
			if (addr == 8'h81)
				wb_reg <= wdata;
		end
	end
	wire [3:0] wm = {wb_reg[4:3], wa_reg[1:0]};
	wire [2:0] cs = wb_reg[2:0];
	wire non_pwm = wm == 4'h0 || wm == 4'h4 || wm == 4'hc;
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	sequence s_hit(v);
		dir_a ##1 (non_pwm && wa_reg[7:6] == v && match_a && dir_a) ##1 dir_a;
	endsequence
	// three cycles let the select settle past the output register
	sequence s_sel(v);
		(cs == v)[*3];
	endsequence
	a_rsvd_zero: assert property ($past(rd_stb) && $past(addr) == 8'h81 |-> !rdata[5])
		else $error("reserved bit read as one");
	a_hit_toggle: assert property (s_hit(2'h1) |-> compare_out_a != $past(compare_out_a))
		else $error("toggle action missed");
	a_hit_clear: assert property (s_hit(2'h2) |-> !compare_out_a)
		else $error("clear action missed");
	a_hit_set: assert property (s_hit(2'h3) |-> compare_out_a)
		else $error("set action missed");
	a_ovr_fields: assert property ({override_a, override_b, override_c} ==
		$past({wa_reg[7:6] != 2'h0, wa_reg[5:4] != 2'h0, wa_reg[3:2] != 2'h0}))
		else $error("override does not follow action field");
	a_pad_drive: assert property (pad_oe_a == $past(wa_reg[7:6] != 2'h0 && dir_a))
		else $error("pad enable wrong");
	a_mode_join: assert property (waveform_mode == $past(wm))
		else $error("waveform mode not joined");
	a_cap_top_off: assert property ((top_source == 2'h1)[*8] |-> !capture_flag)
		else $error("capture while capture is top");
	a_flag_pulse: assert property (capture_flag |=> !capture_flag)
		else $error("capture flag longer than one cycle");
	a_stop_quiet: assert property (s_sel(3'h0) |-> !count_enable)
		else $error("count while stopped");
	a_div1_every: assert property (s_sel(3'h1) |-> count_enable)
		else $error("undivided clock missed a cycle");
	a_div8_gap: assert property (s_sel(3'h2) ##0 count_enable |=>
		(!count_enable)[*7] ##1 (count_enable || cs != 3'h2))
		else $error("divide by eight spacing wrong");
	a_ext_single: assert property ((cs[2:1] == 2'b11)[*3] ##0 count_enable |=> !count_enable)
		else $error("external count pulse too long");
endmodule

/* File: tmc_mode_control_tb.sv */
`timescale 1ns/1ps
module tmc_mode_control_tb;
	localparam logic [63:0] WT = 64'h4451_2233_4441_2220;
	localparam logic [63:0] TP = 64'h2132_2121_0002_0000;
	localparam logic [63:0] RS = 64'h0000_0000_3210_3210;
	localparam logic [23:0] DV = 24'ha8_6300;
	logic clock = 1'b0, rst = 1'b1, wr_stb = 1'b0, rd_stb = 1'b0, pwm_up = 1'b0;
	logic match_a = 1'b0, match_b = 1'b0, match_c = 1'b0, dir_a = 1'b0, dir_b = 1'b0, dir_c = 1'b0;
	logic capture_pin = 1'b0, external_count_pin = 1'b0;
	logic [7:0] addr = 8'h00, wdata = 8'h00;
	logic [15:0] counter_value = 16'h0000, c0;
	wire [7:0] rdata;
	wire count_enable, compare_out_a, compare_out_b, compare_out_c, pad_oe_a, pad_oe_b, pad_oe_c;
	wire override_a, override_b, override_c, capture_flag;
	wire [3:0] waveform_mode;
	wire [2:0] wave_type;
	wire [1:0] top_source, fixed_resolution;
	wire [15:0] capture_value;
	int bad_count = 0, num_checks = 0, n0, n1, n2, n3;
	always #5 clock = ~clock;
	always @(posedge clock) counter_value <= counter_value + 16'h0001;
	tmc_mode_control dut_u (.clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
		.rd_stb(rd_stb), .rdata(rdata), .match_a(match_a), .match_b(match_b), .match_c(match_c),
		.pwm_up(pwm_up), .dir_a(dir_a), .dir_b(dir_b), .dir_c(dir_c), .counter_value(counter_value),
		.capture_pin(capture_pin), .external_count_pin(external_count_pin), .count_enable(count_enable),
		.waveform_mode(waveform_mode), .wave_type(wave_type), .top_source(top_source),
		.fixed_resolution(fixed_resolution), .compare_out_a(compare_out_a), .compare_out_b(compare_out_b),
		.compare_out_c(compare_out_c), .pad_oe_a(pad_oe_a), .pad_oe_b(pad_oe_b), .pad_oe_c(pad_oe_c),
		.override_a(override_a), .override_b(override_b), .override_c(override_c),
		.capture_value(capture_value), .capture_flag(capture_flag));
	task complete_run;
		if (bad_count == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task chk(input logic [15:0] s, input logic [15:0] e);
		num_checks++;
		if (s !== e) begin
			bad_count++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		wr_stb <= 1'b1;
		@(posedge clock);
		wr_stb <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clock);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge clock);
		rd_stb <= 1'b0;
		#1 chk(rdata, e);
	endtask
	// sel 0 watches the capture flag, 1 the count enable
	task watch(input bit sel, input int w, output int n, output int at);
		n = 0;
		at = w;
		for (int i = 0; i < w; i++) begin
			@(posedge clock);
			#1;
			if ((sel ? count_enable : capture_flag) === 1'b1) begin
				if (n == 0)
					at = i;
				n++;
			end
		end
	endtask
	task pin(input bit sel, input logic v, output int n, output int at);
		@(posedge clock);
		c0 = counter_value;
		if (sel)
			external_count_pin <= v;
		else
			capture_pin <= v;
		watch(sel, 24, n, at);
	endtask
	task hit;
		@(posedge clock);
		match_a <= 1'b1;
		match_b <= 1'b1;
		match_c <= 1'b1;
		@(posedge clock);
		match_a <= 1'b0;
		match_b <= 1'b0;
		match_c <= 1'b0;
		repeat (2) @(posedge clock);
		#1;
	endtask
	initial begin
		repeat (11) @(posedge clock);
		#1 chk({count_enable, override_a, pad_oe_a, capture_flag, rdata}, 12'h000);
		@(posedge clock);
		rst <= 1'b0;
		rd(8'h80, 8'h00);
		rd(8'h81, 8'h00);
		wr(8'h81, 8'hff);
		rd(8'h81, 8'hdf);
		wr(8'h82, 8'h5a);
		rd(8'h82, 8'h00);
		for (int m = 0; m < 16; m++) begin
			wr(8'h80, {6'h00, m[1:0]});
			wr(8'h81, {3'h0, m[3:2], 3'h0});
			repeat (2) @(posedge clock);
			#1 chk({waveform_mode, 1'b0, wave_type, 2'h0, top_source, 2'h0, fixed_resolution},
				{m[3:0], 1'b0, WT[4*m+:3], 2'h0, TP[4*m+:2], 2'h0, RS[4*m+:2]});
		end
		wr(8'h80, 8'h00);
		for (int e = 0; e < 2; e++) begin
			wr(8'h81, {1'b0, e[0], 6'h00});
			pin(1'b0, 1'b1, n0, n1);
			chk(n0, e);
			pin(1'b0, 1'b0, n0, n2);
			chk(n0, 1 - e);
		end
		wr(8'h81, 8'hc0);
		@(posedge clock);
		capture_pin <= 1'b1;
		repeat (2) @(posedge clock);
		capture_pin <= 1'b0;
		watch(1'b0, 24, n0, n2);
		chk(n0, 0);
		pin(1'b0, 1'b1, n0, n3);
		chk(n0, 1);
		chk((n3 - n1) inside {3, 4}, 1);
		chk(capture_value - c0 < 16'd20, 1);
		pin(1'b0, 1'b0, n0, n2);
		wr(8'h81, 8'h50);
		pin(1'b0, 1'b1, n0, n2);
		chk(n0, 0);
		pin(1'b0, 1'b0, n0, n2);
		wr(8'h80, 8'h02);
		wr(8'h81, 8'h58);
		pin(1'b0, 1'b1, n0, n2);
		chk(n0, 0);
		wr(8'h80, 8'h00);
		for (int c = 0; c < 6; c++) begin
			wr(8'h81, {5'h00, c[2:0]});
			repeat (4) @(posedge clock);
			watch(1'b1, 2048, n0, n2);
			chk(n0, c == 0 ? 0 : 2048 >> DV[4*c+:4]);
		end
		for (int e = 0; e < 2; e++) begin
			wr(8'h81, {5'h00, 2'b11, e[0]});
			pin(1'b1, 1'b1, n0, n2);
			chk(n0, e);
			pin(1'b1, 1'b0, n0, n2);
			chk(n0, 1 - e);
		end
		wr(8'h81, 8'h00);
		dir_a <= 1'b1;
		dir_b <= 1'b1;
		dir_c <= 1'b1;
		for (int a = 3; a > 0; a--) begin
			wr(8'h80, {a[1:0], 2'h0, a[1:0], 2'h0});
			hit();
			chk({compare_out_a, override_a, pad_oe_a, override_b, pad_oe_b, compare_out_b}, {a[0], 5'h18});
			chk({compare_out_c, override_c, pad_oe_c}, {a[0], 2'h3});
		end
		@(posedge clock);
		dir_a <= 1'b0;
		repeat (2) @(posedge clock);
		#1 chk({pad_oe_a, compare_out_a, override_a}, 3'h1);
		@(posedge clock);
		dir_a <= 1'b1;
		for (int k = 0; k < 4; k++) begin
			wr(8'h80, {1'b1, k[1], 6'h01});
			pwm_up <= k[0];
			hit();
			chk(compare_out_a, k[1] ? k[0] : !k[0]);
		end
		complete_run();
	end
	initial begin
		#400000;
		bad_count++;
		complete_run();
	end
endmodule
bind tmc_mode_control tmc_mode_control_asserts chk_u (.clock(clock), .rst(rst), .addr(addr), .wdata(wdata),
	.wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .match_a(match_a), .dir_a(dir_a),
	.count_enable(count_enable), .waveform_mode(waveform_mode), .top_source(top_source),
	.compare_out_a(compare_out_a), .pad_oe_a(pad_oe_a), .override_a(override_a), .override_b(override_b),
	.override_c(override_c), .capture_flag(capture_flag));

/* File: tmc_prescaler.v */
`timescale 1ns/1ps
`include "tmc_regs.vh"
module tmc_prescaler (
	clock,
	rst,
	tick_div8,
	tick_div64,
	tick_div256,
	tick_div1024
);
	input wire clock;
	input wire rst;
	output reg tick_div8;
	output reg tick_div64;
	output reg tick_div256;
	output reg tick_div1024;

	reg [`TMC_DIV_W-1:0] count_reg;

	// free-running; each tick is a one-cycle enable when the low bits wrap
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			count_reg <= {`TMC_DIV_W{1'b0}};
			tick_div8 <= 1'b0;
			tick_div64 <= 1'b0;
			tick_div256 <= 1'b0;
			tick_div1024 <= 1'b0;
		end else begin
			count_reg <= count_reg + {{(`TMC_DIV_W-1){1'b0}}, 1'b1};
			tick_div8 <= (count_reg & `TMC_DIV8_MASK) == `TMC_DIV8_MASK;
			tick_div64 <= (count_reg & `TMC_DIV64_MASK) == `TMC_DIV64_MASK;
			tick_div256 <= (count_reg & `TMC_DIV256_MASK) == `TMC_DIV256_MASK;
			tick_div1024 <= (count_reg & `TMC_DIV1024_MASK) == `TMC_DIV1024_MASK;
		end
	end
endmodule

/* File: tmc_regs.vh */
`ifndef TMC_REGS_VH
`define TMC_REGS_VH
`define TMC_ADDR_W 8
`define TMC_OFS_WAVE_CTRL 8'h80
`define TMC_OFS_CAP_CLK_CTRL 8'h81
`define TMC_RESET_BYTE 8'h00
`define TMC_CAP_CLK_WMASK 8'hdf
`define TMC_A_HI 7
`define TMC_A_LO 6
`define TMC_B_HI 5
`define TMC_B_LO 4
`define TMC_C_HI 3
`define TMC_C_LO 2
`define TMC_WML_HI 1
`define TMC_WML_LO 0
`define TMC_FILT_BIT 7
`define TMC_EDGE_BIT 6
`define TMC_WMH_HI 4
`define TMC_WMH_LO 3
`define TMC_CS_HI 2
`define TMC_CS_LO 0
`define TMC_ACT_OFF 2'h0
`define TMC_ACT_TOGGLE 2'h1
`define TMC_ACT_CLEAR 2'h2
`define TMC_ACT_SET 2'h3
`define TMC_WM_NORMAL 4'h0
`define TMC_WM_PC8 4'h1
`define TMC_WM_PC9 4'h2
`define TMC_WM_PC10 4'h3
`define TMC_WM_CTC_A 4'h4
`define TMC_WM_FAST8 4'h5
`define TMC_WM_FAST9 4'h6
`define TMC_WM_FAST10 4'h7
`define TMC_WM_PFC_CAP 4'h8
`define TMC_WM_PFC_A 4'h9
`define TMC_WM_PC_CAP 4'ha
`define TMC_WM_PC_A 4'hb
`define TMC_WM_CTC_A2 4'hc
`define TMC_WM_RSVD 4'hd
`define TMC_WM_FAST_CAP 4'he
`define TMC_WM_FAST_A 4'hf
`define TMC_TYPE_NORMAL 3'h0
`define TMC_TYPE_CTC 3'h1
`define TMC_TYPE_PC 3'h2
`define TMC_TYPE_PFC 3'h3
`define TMC_TYPE_FAST 3'h4
`define TMC_TYPE_RSVD 3'h5
`define TMC_TOP_FIXED 2'h0
`define TMC_TOP_CAPTURE 2'h1
`define TMC_TOP_COMPARE_A 2'h2
`define TMC_TOP_NONE 2'h3
`define TMC_RES_NONE 2'h0
`define TMC_RES_8 2'h1
`define TMC_RES_9 2'h2
`define TMC_RES_10 2'h3
`define TMC_CS_STOP 3'h0
`define TMC_CS_DIV1 3'h1
`define TMC_CS_DIV8 3'h2
`define TMC_CS_DIV64 3'h3
`define TMC_CS_DIV256 3'h4
`define TMC_CS_DIV1024 3'h5
`define TMC_CS_EXT_FALL 3'h6
`define TMC_CS_EXT_RISE 3'h7
`define TMC_DIV_W 10
`define TMC_DIV8_MASK 10'h007
`define TMC_DIV64_MASK 10'h03f
`define TMC_DIV256_MASK 10'h0ff
`define TMC_DIV1024_MASK 10'h3ff
`define TMC_FILTER_SAMPLES 4
`endif
